// ---- verilog/cdm_pkg.sv ----
package cdm_pkg;
    // ==================================================
    // Register map
    localparam logic [7:0]  CDM_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  CDM_RESULT_OFS  = 8'h04;
    localparam logic [7:0]  CDM_FLAGS_OFS   = 8'h08;
    localparam logic [7:0]  CDM_STATUS_OFS  = 8'h0c;
    localparam logic [7:0]  CDM_GATE_OFS    = 8'h10;
    // ==================================================
    // Field positions
    localparam int          CDM_EN_BIT      = 0;
    localparam int          CDM_SLOW_BIT    = 1;
    localparam int          CDM_DP_LSB      = 2;
    localparam int          CDM_DPE_BIT     = 5;
    localparam int          CDM_OVF_BIT     = 0;
    // ==================================================
    // Reset values
    localparam logic        CDM_EN_RST      = 1'b1;
    localparam logic        CDM_SLOW_RST    = 1'b0;
    localparam logic [2:0]  CDM_DP_RST      = 3'h0;
    localparam logic        CDM_DPE_RST     = 1'b0;
    localparam logic [31:0] CDM_RESULT_RST  = 32'h0000_0000;
    localparam logic [23:0] CDM_GATE_RST    = 24'h0186a0;
    // ==================================================
    // Timing
    localparam int          CDM_CLK_MHZ     = 40;
    localparam int          CDM_TICK_US     = 1;
    localparam int          CDM_TICK_CYC    = CDM_CLK_MHZ * CDM_TICK_US;
    localparam int          CDM_SLOW_DIV    = 4;
    localparam int          CDM_DIGIT_US    = 244;
    localparam int          CDM_GAP_US      = 6;
    localparam int          CDM_STORE_US    = 10;
    localparam int          CDM_INTERVAL_MS = 200;
    localparam int          CDM_DIGIT_TICKS = CDM_DIGIT_US / CDM_TICK_US;
    localparam int          CDM_GAP_TICKS   = CDM_GAP_US / CDM_TICK_US;
    localparam int          CDM_STORE_TICKS = CDM_STORE_US / CDM_TICK_US;
    localparam int          CDM_INTV_TICKS  = CDM_INTERVAL_MS * 1000 / CDM_TICK_US;
    // ==================================================
    // Measurement sequencer
    typedef enum logic [1:0] {
        SEQ_MEAS  = 2'b00,
        SEQ_STORE = 2'b01,
        SEQ_WAIT  = 2'b10
    } cdm_seq_e;
endpackage

// ---- verilog/cdm_scan_if.sv ----
`timescale 1ns/1ps
interface cdm_scan_if;
    logic       tick;
    logic [2:0] idx;
    logic       on;
    modport scan (input tick, output idx, output on);
    modport user (output tick, input idx, input on);
endinterface

// ---- verilog/cdm_scan.sv ----
`timescale 1ns/1ps
module cdm_scan #(
    parameter int DIGIT_TICKS = 244,
    parameter int GAP_TICKS   = 6
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    cdm_scan_if.scan  sc
);
    import cdm_pkg::*;

    typedef struct packed {
        logic [2:0]  idx;
        logic        on;
        logic [15:0] cnt;
    } cdm_scan_s;

    cdm_scan_s s_r;
    cdm_scan_s s_nxt;

    // ==================================================
    // Slot timer: gap then drive, top digit first
    always_comb begin
        s_nxt = s_r;
        if (sc.tick) begin
            if (s_r.on) begin
                if (s_r.cnt == 16'(DIGIT_TICKS - 1)) begin
                    s_nxt.on  = 1'b0;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.idx = s_r.idx - 3'h1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                end
            end else if (s_r.cnt == 16'(GAP_TICKS - 1)) begin
                s_nxt.on  = 1'b1;
                s_nxt.cnt = 16'h0000;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{idx: 3'h7, on: 1'b0, cnt: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sc.idx = s_r.idx;
    assign sc.on  = s_r.on;

    // ==================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_digit_order: assert property ($changed(s_r.idx) |-> s_r.idx == $past(s_r.idx) - 3'h1)
        else $error("digit scan order broken");
    chk_drive_bound: assert property (s_r.on |-> s_r.cnt < 16'(DIGIT_TICKS))
        else $error("digit drive too long");
    chk_gap_bound: assert property (!s_r.on |-> s_r.cnt < 16'(GAP_TICKS))
        else $error("blanking gap too long");
endmodule

// ---- verilog/cdm_mux.sv ----
`timescale 1ns/1ps
module cdm_mux #(
    parameter int DIGIT_TICKS = cdm_pkg::CDM_DIGIT_TICKS,
    parameter int GAP_TICKS   = cdm_pkg::CDM_GAP_TICKS,
    parameter int INTV_TICKS  = cdm_pkg::CDM_INTV_TICKS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        hold_in,
    output logic [7:0]       digit_strobe,
    output logic [6:0]       seg,
    output logic             seg_dp,
    output logic [3:0]       bcd,
    output logic             store_strobe,
    output logic             meas_idle
);
    import cdm_pkg::*;

    typedef struct packed {
        logic        hold_s1;
        logic        hold_s2;
        logic        hold_q;
        logic [7:0]  addr;
        logic        wr_pend;
        logic [31:0] rdata;
        logic        en;
        logic        slow;
        logic [2:0]  dp;
        logic        dpe;
        logic [31:0] result;
        logic        ovf;
        logic [23:0] gate;
        logic [7:0]  pre;
        logic        tick;
        cdm_seq_e    seq;
        logic [23:0] cnt;
        logic [31:0] disp;
        logic        dovf;
        logic [7:0]  digit;
        logic [6:0]  seg;
        logic        dp_out;
        logic [3:0]  bcd;
    } cdm_mux_s;

    cdm_mux_s   s_r;
    cdm_mux_s   s_nxt;
    cdm_scan_if sc ();
    logic [7:0] blank;
    logic       hold_fall;

    // ==================================================
    // Helpers
    function automatic logic [6:0] cdm_seg7(input logic [3:0] d);
        logic [6:0] g;
        case (d)
            4'h0:    g = 7'h3f;
            4'h1:    g = 7'h06;
            4'h2:    g = 7'h5b;
            4'h3:    g = 7'h4f;
            4'h4:    g = 7'h66;
            4'h5:    g = 7'h6d;
            4'h6:    g = 7'h7d;
            4'h7:    g = 7'h07;
            4'h8:    g = 7'h7f;
            4'h9:    g = 7'h6f;
            default: g = 7'h40;
        endcase
        return g;
    endfunction

    // Bit set means that digit is a suppressed leading zero
    function automatic logic [7:0] cdm_blank(input logic [31:0] v, input logic [2:0] dp,
                                             input logic dpe, input logic ovf);
        logic       lead;
        logic [7:0] m;
        lead = 1'b1;
        m    = 8'h00;
        for (int i = 7; i >= 1; i--) begin
            if (v[i*4 +: 4] != 4'h0) begin
                lead = 1'b0;
            end
            if (dpe && 3'(i) <= dp) begin
                lead = 1'b0;
            end
            m[i] = lead & ~ovf;
        end
        return m;
    endfunction

    assign blank     = cdm_blank(s_r.disp, s_r.dp, s_r.dpe, s_r.dovf);
    assign hold_fall = s_r.hold_q & ~s_r.hold_s2;

    cdm_scan #(
        .DIGIT_TICKS (DIGIT_TICKS),
        .GAP_TICKS   (GAP_TICKS)
    ) u_scan (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sc      (sc.scan)
    );

    assign sc.tick = s_r.tick;

    // ==================================================
    // Next state
    always_comb begin
        logic [31:0] rd;
        logic [3:0]  dig;
        logic [7:0]  pre_max;
        rd      = 32'h0000_0000;
        dig     = s_r.disp[sc.idx*4 +: 4];
        pre_max = s_r.slow ? 8'(CDM_TICK_CYC * CDM_SLOW_DIV - 1) : 8'(CDM_TICK_CYC - 1);
        s_nxt   = s_r;

        // Hold pin comes from outside: two stages before use
        s_nxt.hold_s1 = hold_in;
        s_nxt.hold_s2 = s_r.hold_s1;
        s_nxt.hold_q  = s_r.hold_s2;

        // Bus data phase; zero wait states, unmapped writes dropped
        s_nxt.wr_pend = 1'b0;
        if (s_r.wr_pend) begin
            case (s_r.addr)
                CDM_CTRL_OFS: begin
                    s_nxt.en   = hwdata[CDM_EN_BIT];
                    s_nxt.slow = hwdata[CDM_SLOW_BIT];
                    s_nxt.dp   = hwdata[CDM_DP_LSB +: 3];
                    s_nxt.dpe  = hwdata[CDM_DPE_BIT];
                end
                CDM_RESULT_OFS: s_nxt.result = hwdata;
                CDM_FLAGS_OFS:  s_nxt.ovf    = hwdata[CDM_OVF_BIT];
                CDM_GATE_OFS:   s_nxt.gate   = hwdata[23:0];
                default: ;
            endcase
        end
        // Read data is sampled in the address phase so hrdata is a flop
        case (haddr[7:0])
            CDM_CTRL_OFS: begin
                rd[CDM_EN_BIT]          = s_r.en;
                rd[CDM_SLOW_BIT]        = s_r.slow;
                rd[CDM_DP_LSB +: 3]     = s_r.dp;
                rd[CDM_DPE_BIT]         = s_r.dpe;
            end
            CDM_RESULT_OFS: rd = s_r.result;
            CDM_FLAGS_OFS:  rd[CDM_OVF_BIT] = s_r.ovf;
            CDM_STATUS_OFS: rd = {25'h0, s_r.hold_s2, sc.idx, sc.on, s_r.seq};
            CDM_GATE_OFS:   rd = {8'h00, s_r.gate};
            default:        rd = 32'h0000_0000;
        endcase
        if (hsel && htrans[1] && hready) begin
            s_nxt.addr    = haddr[7:0];
            s_nxt.wr_pend = hwrite;
            s_nxt.rdata   = rd;
        end

        // Timebase tick; slow mode divides it further
        s_nxt.tick = 1'b0;
        if (s_r.pre >= pre_max) begin
            s_nxt.pre  = 8'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.pre = s_r.pre + 8'h01;
        end

        // Measurement sequencer
        if (hold_fall) begin
            s_nxt.seq = SEQ_MEAS;
            s_nxt.cnt = 24'h000000;
        end else if (s_r.tick) begin
            case (s_r.seq)
                SEQ_MEAS: begin
                    if (s_r.gate == 24'h0 || s_r.cnt >= s_r.gate - 24'h1) begin
                        s_nxt.seq  = SEQ_STORE;
                        s_nxt.cnt  = 24'h000000;
                        // Result arrives already counted; its +-1 count and
                        // oscillator-derived error are passed through as is
                        s_nxt.disp = s_r.result;
                        s_nxt.dovf = s_r.ovf;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 24'h1;
                    end
                end
                SEQ_STORE: begin
                    if (s_r.cnt >= 24'(CDM_STORE_TICKS - 1)) begin
                        s_nxt.seq = SEQ_WAIT;
                        s_nxt.cnt = 24'h000000;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 24'h1;
                    end
                end
                SEQ_WAIT: begin
                    // Held hold freezes here, so store looped to hold stops after one
                    if (!s_r.hold_s2) begin
                        if (s_r.cnt >= 24'(INTV_TICKS - 1)) begin
                            s_nxt.seq = SEQ_MEAS;
                            s_nxt.cnt = 24'h000000;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 24'h1;
                        end
                    end
                end
                default: begin
                    s_nxt.seq = SEQ_WAIT;
                    s_nxt.cnt = 24'h000000;
                end
            endcase
        end

        // Display drive; BCD follows the slot index even in the gap
        s_nxt.bcd = dig;
        if (sc.on && s_r.en) begin
            s_nxt.digit  = 8'h01 << sc.idx;
            s_nxt.seg    = blank[sc.idx] ? 7'h00 : cdm_seg7(dig);
            s_nxt.dp_out = (sc.idx == 3'h7 && s_r.dovf) ||
                           (s_r.dpe && sc.idx == s_r.dp);
        end else begin
            s_nxt.digit  = 8'h00;
            s_nxt.seg    = 7'h00;
            s_nxt.dp_out = 1'b0;
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{hold_s1: 1'b0, hold_s2: 1'b0, hold_q: 1'b0, addr: 8'h00,
                     wr_pend: 1'b0, rdata: 32'h0000_0000, en: CDM_EN_RST,
                     slow: CDM_SLOW_RST, dp: CDM_DP_RST, dpe: CDM_DPE_RST,
                     result: CDM_RESULT_RST, ovf: 1'b0, gate: CDM_GATE_RST,
                     pre: 8'h00, tick: 1'b0, seq: SEQ_MEAS, cnt: 24'h000000,
                     disp: CDM_RESULT_RST, dovf: 1'b0, digit: 8'h00, seg: 7'h00,
                     dp_out: 1'b0, bcd: 4'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================
    // Outputs
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s_r.rdata;
    assign digit_strobe = s_r.digit;
    assign seg          = s_r.seg;
    assign seg_dp       = s_r.dp_out;
    assign bcd          = s_r.bcd;
    assign store_strobe = (s_r.seq == SEQ_STORE);
    assign meas_idle    = (s_r.seq != SEQ_MEAS);

    // ==================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_gap_dark: assert property ((s_r.digit == 8'h00) |-> (s_r.seg == 7'h00 && !s_r.dp_out))
        else $error("segments lit during gap");
    chk_one_digit: assert property ($onehot0(s_r.digit))
        else $error("more than one digit driven");
    chk_bcd_top: assert property (s_r.digit[7] |-> s_r.bcd == $past(s_r.disp[31:28]))
        else $error("bcd does not show top digit");
    chk_ovf_point: assert property ((s_r.digit[7] && $past(s_r.dovf)) |-> s_r.dp_out)
        else $error("overflow point not lit");
    chk_ovf_noblank: assert property (s_r.dovf |-> blank == 8'h00)
        else $error("blanking while overflowed");
    chk_point_right: assert property (s_r.dpe |-> (blank & ((8'h02 << s_r.dp) - 8'h01)) == 8'h00)
        else $error("digit at or right of point blanked");
    chk_hold_restart: assert property (hold_fall |=> (s_r.seq == SEQ_MEAS && s_r.cnt == 24'h0))
        else $error("hold release did not restart");
    chk_hold_freeze: assert property ((s_r.seq == SEQ_WAIT && s_r.hold_s2) |=> s_r.seq == SEQ_WAIT)
        else $error("wait left while hold high");
    chk_tick_space: assert property (s_r.tick |=> !s_r.tick [*8])
        else $error("timebase ticks too close");
endmodule

// ---- tb/cdm_disp_model.sv ----
`timescale 1ns/1ps
// ==================================================
// Display stand-in with store-to-hold feedback
module cdm_disp_model (
    input  wire logic        hclk,
    input  wire logic [7:0]  digit_strobe,
    input  wire logic [6:0]  seg,
    input  wire logic        seg_dp,
    input  wire logic [3:0]  bcd,
    input  wire logic        store_strobe,
    input  wire logic        hold_req,
    input  wire logic        single_en,
    output logic             hold_in,
    output logic [31:0]      lat_bcd,
    output logic [63:0]      lat_seg,
    output logic             order_bad,
    output logic             fn_in
);
    // Mode-select stand-in: one chosen strobe is routed back as the function input
    localparam int FN_DIGIT = 0;
    logic [7:0] prev_r   = 8'h00;
    logic [2:0] last_r   = 3'h0;
    logic       freeze_r = 1'b0;
    initial begin
        lat_bcd = 32'h0;
        lat_seg = 64'h0;
        order_bad = 1'b0;
    end
    // Latching on the strobe edge only: bcd settles during the gap before it
    always @(posedge hclk) begin
        prev_r <= digit_strobe;
        freeze_r <= single_en & (freeze_r | store_strobe);
        for (int i = 0; i < 8; i++) begin
            if (digit_strobe[i] && !prev_r[i]) begin
                lat_bcd[4*i +: 4] <= bcd;
                lat_seg[8*i +: 8] <= {seg_dp, seg};
                last_r <= 3'(i);
                if (3'(i) != last_r - 3'h1) begin
                    order_bad <= 1'b1;
                end
            end
        end
    end
    assign hold_in = hold_req | freeze_r;
    assign fn_in   = digit_strobe[FN_DIGIT];
endmodule

// ---- tb/counter_display_multiplexer_test.sv ----
`timescale 1ns/1ps
module counter_display_multiplexer_test;
    import cdm_pkg::*;
    // ==================================================
    // Small counts keep the run short
    localparam int DT = 8;
    localparam int GT = 2;
    localparam int IT = 20;
    localparam int TC = CDM_TICK_CYC;
    localparam logic [31:0] CR [5] = '{32'h0, 32'h105, 32'h0, 32'h00700000, 32'h98765430};
    localparam logic [5:0]  CC [5] = '{6'h01, 6'h31, 6'h01, 6'h25, 6'h3d};
    localparam logic        CO [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic        hclk      = 1'b0;
    logic        hresetn   = 1'b0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic        hold_req  = 1'b0;
    logic        single_en = 1'b0;
    logic        hreadyout, hresp, seg_dp, store_strobe, meas_idle, hold_in, order_bad, fn_in;
    logic [31:0] hrdata, lat_bcd;
    logic [7:0]  digit_strobe;
    logic [6:0]  seg;
    logic [3:0]  bcd;
    logic [63:0] lat_seg;
    int          errors    = 0;
    int          compares  = 0;
    int          seed      = 32'hb282;
    always #12.5 hclk = ~hclk;
    cdm_mux #(.DIGIT_TICKS(DT), .GAP_TICKS(GT), .INTV_TICKS(IT)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hold_in(hold_in),
        .digit_strobe(digit_strobe), .seg(seg), .seg_dp(seg_dp), .bcd(bcd),
        .store_strobe(store_strobe), .meas_idle(meas_idle));
    cdm_disp_model disp (
        .hclk(hclk), .digit_strobe(digit_strobe), .seg(seg), .seg_dp(seg_dp), .bcd(bcd),
        .store_strobe(store_strobe), .hold_req(hold_req), .single_en(single_en),
        .hold_in(hold_in), .lat_bcd(lat_bcd), .lat_seg(lat_seg), .order_bad(order_bad),
        .fn_in(fn_in));
    // ==================================================
    // Expectations
    function automatic logic [6:0] seg7(input logic [3:0] d);
        case (d)
            4'h0: seg7 = 7'h3f;  4'h1: seg7 = 7'h06;  4'h2: seg7 = 7'h5b;  4'h3: seg7 = 7'h4f;
            4'h4: seg7 = 7'h66;  4'h5: seg7 = 7'h6d;  4'h6: seg7 = 7'h7d;  4'h7: seg7 = 7'h07;
            4'h8: seg7 = 7'h7f;  4'h9: seg7 = 7'h6f;  default: seg7 = 7'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_disp(logic [31:0] r, logic [5:0] c, logic o, int i);
        logic lead;
        lead = 1'b1;
        for (int k = 7; k >= i; k--) if (r[4*k +: 4] != 4'h0) lead = 1'b0;
        if (o || i == 0 || (c[5] && 3'(i) <= c[4:2])) lead = 1'b0;
        exp_disp = {(c[5] && c[4:2] == 3'(i)) || (o && i == 7), lead ? 7'h00 : seg7(r[4*i +: 4])};
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: pick = |digit_strobe;
            1: pick = store_strobe;
            2: pick = meas_idle;
            3: pick = digit_strobe[7];
            default: pick = fn_in;
        endcase
    endfunction
    // ==================================================
    // Bench tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_lvl(input int w, input logic v);
        int n;
        n = 0;
        while (pick(w) !== v && n < 40000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 40000) chk("wait", 32'h1, 32'h0);
    endtask
    task automatic span(input int w, output int hi, output int lo);
        wait_lvl(w, 1'b0);
        wait_lvl(w, 1'b1);
        hi = 0;
        lo = 0;
        while (pick(w) === 1'b1 && hi < 40000) begin
            @(posedge hclk);
            hi++;
        end
        while (pick(w) === 1'b0 && lo < 40000) begin
            @(posedge hclk);
            lo++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask
    task automatic restart_chk(input string nm);
        int n;
        n = 0;
        while (meas_idle !== 1'b0 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        chk(nm, 32'h1, 32'(n <= 8));
    endtask
    // A hold pulse restarts the count so new data shows without a full interval
    task automatic show(input logic [31:0] r, input logic [5:0] c, input logic o);
        wr(CDM_RESULT_OFS, r);
        wr(CDM_FLAGS_OFS, {31'h0, o});
        wr(CDM_CTRL_OFS, {26'h0, c});
        hold_req <= 1'b1;
        repeat (4) @(posedge hclk);
        hold_req <= 1'b0;
        restart_chk("hold restart");
        wait_lvl(1, 1'b1);
        wait_lvl(3, 1'b0);
        wait_lvl(3, 1'b1);
        wait_lvl(4, 1'b1);
        wait_lvl(4, 1'b0);
        for (int i = 0; i < 8; i++) begin
            chk("bcd", {28'h0, r[4*i +: 4]}, {28'h0, lat_bcd[4*i +: 4]});
            chk("segs", {24'h0, exp_disp(r, c, o, i)}, {24'h0, lat_seg[8*i +: 8]});
        end
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==================================================
    // Checks on every cycle
    always @(posedge hclk) begin
        if (hresetn === 1'b1 && digit_strobe === 8'h00) begin
            chk("gap dark", 32'h0, {24'h0, seg_dp, seg});
        end
    end
    initial begin
        // Worst case of all scenarios stays below this span
        repeat (100000) @(posedge hclk);
        errors++;
        conclude();
    end
    // ==================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [5:0]  c;
        logic [15:0] acc;
        int          hi, lo, z;
        repeat (5) @(posedge hclk);
        chk("reset drive", 32'h0, {14'h0, digit_strobe, seg, seg_dp, store_strobe, meas_idle});
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("ctrl rst", CDM_CTRL_OFS, 32'h1);
        rdchk("result rst", CDM_RESULT_OFS, CDM_RESULT_RST);
        rdchk("flags rst", CDM_FLAGS_OFS, 32'h0);
        rdchk("gate rst", CDM_GATE_OFS, {8'h0, CDM_GATE_RST});
        rdchk("unmapped", 8'h14, 32'h0);
        wr(CDM_GATE_OFS, 32'd10);
        rdchk("gate", CDM_GATE_OFS, 32'd10);
        for (int t = 0; t < 7; t++) begin
            if (t < 5) begin
                show(CR[t], CC[t], CO[t]);
            end else begin
                z = $unsigned($random(seed)) % 8;
                for (int k = 0; k < 8; k++) r[4*k +: 4] = (k < 8 - z) ? 4'($unsigned($random(seed)) % 10) : 4'h0;
                c = (6'($unsigned($random(seed))) & 6'h3c) | 6'h01;
                show(r, c, 1'($random(seed)));
            end
        end
        span(0, hi, lo);
        chk("digit time", DT * TC, hi);
        chk("blank gap", GT * TC, lo);
        span(3, hi, lo);
        chk("scan", 8 * (DT + GT) * TC, hi + lo);
        span(2, hi, lo);
        chk("interval", (CDM_STORE_TICKS + IT) * TC, hi);
        wr(CDM_CTRL_OFS, 32'h3);
        span(0, hi, lo);
        chk("slow digit", DT * TC * CDM_SLOW_DIV, hi);
        span(2, hi, lo);
        chk("slow interval", (CDM_STORE_TICKS + IT) * TC * CDM_SLOW_DIV, hi);
        wr(CDM_CTRL_OFS, 32'h1);
        wait_lvl(1, 1'b1);
        wait_lvl(1, 1'b0);
        hold_req <= 1'b1;
        repeat (3) @(posedge hclk);
        hold_req <= 1'b0;
        restart_chk("early restart");
        single_en <= 1'b1;
        wait_lvl(1, 1'b1);
        repeat ((CDM_STORE_TICKS + IT) * TC + 600) @(posedge hclk);
        chk("frozen", 32'h1, {31'h0, meas_idle});
        single_en <= 1'b0;
        restart_chk("release");
        wr(CDM_CTRL_OFS, 32'h0);
        repeat (10) @(posedge hclk);
        acc = 16'h0;
        repeat (8 * (DT + GT) * TC) begin
            @(posedge hclk);
            acc = acc | {digit_strobe, seg_dp, seg};
        end
        chk("display off", 32'h0, {16'h0, acc});
        chk("order", 32'h0, {31'h0, order_bad});
        conclude();
    end
endmodule
